//--- common/sfpes_pkg.sv
`default_nettype none
package sfpes_pkg;
    // ------------------------------------------------------------
    // command codes (kept as parameters, values arbitrary defaults)
    // ------------------------------------------------------------
    localparam logic [7:0] OP_WREN = 8'h06;
    localparam logic [7:0] OP_WRDI = 8'h04;
    localparam logic [7:0] OP_OTP_PROG = 8'h42;
    localparam logic [7:0] OP_LOCK_WR = 8'hE5;
    localparam logic [7:0] OP_SUB_ERASE = 8'h20;
    localparam logic [7:0] OP_SEC_ERASE = 8'hD8;
    localparam logic [7:0] OP_BULK_ERASE = 8'hC7;
    localparam logic [7:0] OP_SLEEP = 8'hB9;
    localparam logic [7:0] OP_WAKE = 8'hAB;

    // ------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------
    localparam int OTP_BYTES = 64;
    localparam int OTP_MAX_LATCH = 65;
    localparam int OTP_CTRL_IDX = 64;
    localparam int OTP_LOCK_BIT = 0;
    localparam int SECTORS = 32;
    localparam int SEC_LSB = 16;
    localparam int SEC_W = 5;
    localparam int LOCK_DOWN_BIT = 1;
    localparam int WRITE_LOCK_BIT = 0;

    // ------------------------------------------------------------
    // timing, in ns, and cycles at 20 ns clock
    // ------------------------------------------------------------
    localparam int CLK_NS = 20;
    localparam int PAGE_WRITE_TIME_NS = 5000;
    localparam int SMALL_ERASE_TIME_NS = 50000;
    localparam int BLOCK_ERASE_TIME_NS = 100000;
    localparam int FULL_ERASE_TIME_NS = 200000;
    localparam int SLEEP_ENTRY_DELAY_NS = 3000;
    localparam int SLEEP_EXIT_DELAY_NS = 30000;
    localparam int PAGE_WRITE_CYC = PAGE_WRITE_TIME_NS / CLK_NS;
    localparam int SMALL_ERASE_CYC = SMALL_ERASE_TIME_NS / CLK_NS;
    localparam int BLOCK_ERASE_CYC = BLOCK_ERASE_TIME_NS / CLK_NS;
    localparam int FULL_ERASE_CYC = FULL_ERASE_TIME_NS / CLK_NS;
    localparam int SLEEP_ENTRY_CYC = SLEEP_ENTRY_DELAY_NS / CLK_NS;
    localparam int SLEEP_EXIT_CYC = SLEEP_EXIT_DELAY_NS / CLK_NS;
    localparam int TMR_W = 24;

    typedef enum logic [2:0] {
        SFPES_JOB_NONE, SFPES_JOB_OTP, SFPES_JOB_SUB, SFPES_JOB_SEC,
        SFPES_JOB_BULK
    } sfpes_job_t;

    typedef enum logic [1:0] {
        SFPES_PWR_STBY, SFPES_PWR_ENTER, SFPES_PWR_SLEEP, SFPES_PWR_EXIT
    } sfpes_pwr_t;

    typedef struct packed {
        logic cycle_active_flag;
        logic write_latch_flag;
        logic sleeping;
        logic [2:0] protect_field;
    } sfpes_status_t;
endpackage : sfpes_pkg
`default_nettype wire

//--- rtl/sfpes_core.sv
`timescale 1ns/1ps
`default_nettype none
module sfpes_core
    import sfpes_pkg::*;
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic chip_sel_n,
    input wire logic serial_clk,
    input wire logic serial_in_line,
    input wire logic [2:0] protect_field,
    input wire logic [SEC_W-1:0] hw_protect_sec,
    input wire logic hw_protect_hit,
    output logic [7:0] otp_read_data,
    input wire logic [6:0] otp_read_idx,
    output logic [7:0] sector_lock_register,
    input wire logic [SEC_W-1:0] lock_read_sec,
    output logic erase_pulse,
    output logic [2:0] erase_kind,
    output logic [23:0] erase_addr,
    output sfpes_status_t status
);
    // ------------------------------------------------------------
    // pin synchronisers and clock edge detect
    // ------------------------------------------------------------
    logic [1:0] cs_s_r, sck_s_r, din_s_r;
    logic sck_d_r, cs_d_r;
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cs_s_r <= 2'h3;
            sck_s_r <= 2'h0;
            din_s_r <= 2'h0;
            sck_d_r <= 1'b0;
            cs_d_r <= 1'b1;
        end else begin
            cs_s_r <= {cs_s_r[0], chip_sel_n};
            sck_s_r <= {sck_s_r[0], serial_clk};
            din_s_r <= {din_s_r[0], serial_in_line};
            sck_d_r <= sck_s_r[1];
            cs_d_r <= cs_s_r[1];
        end
    end
    logic cs_n, sck_rise, cs_rise;
    assign cs_n = cs_s_r[1];
    assign sck_rise = sck_s_r[1] & ~sck_d_r & ~cs_n;
    assign cs_rise = cs_s_r[1] & ~cs_d_r;

    function automatic logic [SEC_W-1:0] sec_of(input logic [23:0] a);
        sec_of = a[SEC_LSB+SEC_W-1:SEC_LSB];
    endfunction : sec_of

    // ------------------------------------------------------------
    // shifter state
    // ------------------------------------------------------------
    logic [7:0] sh_r, sh_nxt, op_r, op_nxt, dat_r, dat_nxt;
    logic [2:0] bit_r, bit_nxt;
    logic [7:0] nbyte_r, nbyte_nxt;
    logic [23:0] addr_r, addr_nxt;
    logic on_bound_r, on_bound_nxt;
    // erased at power-up, srst leaves it alone
    logic [7:0] otp_buf_r [0:OTP_MAX_LATCH-1] = '{default: 8'hFF};
    logic [7:0] otp_new_r [0:OTP_MAX_LATCH-1];
    logic [OTP_MAX_LATCH-1:0] otp_wr_r, otp_wr_nxt;
    logic [6:0] otp_base_r, otp_base_nxt;

    // ------------------------------------------------------------
    // control state
    // ------------------------------------------------------------
    logic wel_r, wel_nxt;
    sfpes_job_t job_r, job_nxt;
    sfpes_pwr_t pwr_r, pwr_nxt;
    logic [TMR_W-1:0] tmr_r, tmr_nxt;
    logic [1:0] lock_r [0:SECTORS-1];
    logic lock_we;
    logic [1:0] lock_wv;
    logic otp_commit;
    logic ep_nxt;
    logic [2:0] ek_nxt;
    logic [23:0] ea_r, ea_nxt;
    logic ep_r;
    logic [2:0] ek_r;
    logic busy, byte_done, prot_sec;

    assign busy = (job_r != SFPES_JOB_NONE);
    assign byte_done = sck_rise && (bit_r == 3'h7);
    assign prot_sec = lock_r[sec_of(addr_r)][WRITE_LOCK_BIT]
        || (hw_protect_hit && hw_protect_sec == sec_of(addr_r));

    always_comb begin
        sh_nxt = sh_r;
        op_nxt = op_r;
        dat_nxt = dat_r;
        bit_nxt = bit_r;
        nbyte_nxt = nbyte_r;
        addr_nxt = addr_r;
        on_bound_nxt = on_bound_r;
        otp_wr_nxt = otp_wr_r;
        otp_base_nxt = otp_base_r;
        if (cs_n) begin
            bit_nxt = 3'h0;
            nbyte_nxt = 8'h00;
            if (cs_rise) begin
                on_bound_nxt = 1'b0;
            end
        end else if (sck_rise) begin
            sh_nxt = {sh_r[6:0], din_s_r[1]};
            bit_nxt = bit_r + 3'h1;
            on_bound_nxt = byte_done;
            if (byte_done) begin
                if (nbyte_r != 8'hFF) begin
                    nbyte_nxt = nbyte_r + 8'h01;
                end
                if (nbyte_r == 8'h00) begin
                    op_nxt = {sh_r[6:0], din_s_r[1]};
                    otp_wr_nxt = '0;
                end else if (nbyte_r < 8'h04) begin
                    addr_nxt = {addr_r[15:0], sh_r[6:0], din_s_r[1]};
                    if (nbyte_r == 8'h03) begin
                        otp_base_nxt = {sh_r[5:0], din_s_r[1]};
                    end
                end else begin
                    dat_nxt = {sh_r[6:0], din_s_r[1]};
                end
            end
        end
    end

    // ------------------------------------------------------------
    // otp data latch: 65 bytes, no wrap, extras dropped
    // ------------------------------------------------------------
    logic [7:0] data_slot;
    logic slot_ok;
    always_comb begin
        data_slot = 8'(otp_base_r) + nbyte_r - 8'h04;
        slot_ok = byte_done && op_r == OP_OTP_PROG && nbyte_r >= 8'h04
            && data_slot < 8'(OTP_MAX_LATCH);
    end
    always_ff @(posedge clk_sys) begin
        if (slot_ok) begin
            otp_new_r[data_slot[6:0]] <= {sh_r[6:0], din_s_r[1]};
        end
    end
    logic [OTP_MAX_LATCH-1:0] wr_mark;
    always_comb begin
        wr_mark = otp_wr_nxt;
        if (slot_ok) begin
            wr_mark[data_slot[6:0]] = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // command decode at deselect
    // ------------------------------------------------------------
    logic term_ok, otp_locked;
    assign term_ok = on_bound_r && !busy;
    assign otp_locked = !otp_buf_r[OTP_CTRL_IDX][OTP_LOCK_BIT];

    always_comb begin
        wel_nxt = wel_r;
        job_nxt = job_r;
        pwr_nxt = pwr_r;
        tmr_nxt = tmr_r;
        lock_we = 1'b0;
        lock_wv = 2'h0;
        otp_commit = 1'b0;
        ep_nxt = 1'b0;
        ek_nxt = ek_r;
        ea_nxt = ea_r;
        if (busy) begin
            if (tmr_r == TMR_W'(1)) begin
                job_nxt = SFPES_JOB_NONE;
            end
            if (tmr_r != '0) begin
                tmr_nxt = tmr_r - TMR_W'(1);
            end
            wel_nxt = 1'b0;                         // latch drops mid-cycle
        end else if (pwr_r == SFPES_PWR_ENTER || pwr_r == SFPES_PWR_EXIT) begin
            if (tmr_r <= TMR_W'(1)) begin
                pwr_nxt = (pwr_r == SFPES_PWR_ENTER) ? SFPES_PWR_SLEEP
                                                     : SFPES_PWR_STBY;
            end
            tmr_nxt = tmr_r - TMR_W'(1);
        end
        if (cs_rise && term_ok && pwr_r == SFPES_PWR_SLEEP) begin
            if (op_r == OP_WAKE && nbyte_r == 8'h01) begin
                pwr_nxt = SFPES_PWR_EXIT;
                tmr_nxt = TMR_W'(SLEEP_EXIT_CYC);
            end
        end else if (cs_rise && term_ok && pwr_r == SFPES_PWR_STBY) begin
            if (nbyte_r == 8'h01 && op_r == OP_WREN) begin
                wel_nxt = 1'b1;
            end else if (nbyte_r == 8'h01 && op_r == OP_WRDI) begin
                wel_nxt = 1'b0;
            end else if (nbyte_r == 8'h01 && op_r == OP_SLEEP) begin
                pwr_nxt = SFPES_PWR_ENTER;
                tmr_nxt = TMR_W'(SLEEP_ENTRY_CYC);
            end else if (wel_r) begin
                if (op_r == OP_OTP_PROG && nbyte_r >= 8'h05) begin
                    job_nxt = SFPES_JOB_OTP;
                    tmr_nxt = TMR_W'(PAGE_WRITE_CYC);
                    otp_commit = !otp_locked;
                end else if (op_r == OP_LOCK_WR && nbyte_r == 8'h05) begin
                    wel_nxt = 1'b0;
                    lock_we = !lock_r[sec_of(addr_r)][LOCK_DOWN_BIT];
                    lock_wv = {dat_r[LOCK_DOWN_BIT],
                               dat_r[WRITE_LOCK_BIT]};
                end else if ((op_r == OP_SUB_ERASE || op_r == OP_SEC_ERASE)
                             && nbyte_r == 8'h04) begin
                    job_nxt = (op_r == OP_SUB_ERASE) ? SFPES_JOB_SUB
                                                     : SFPES_JOB_SEC;
                    tmr_nxt = (op_r == OP_SUB_ERASE)
                        ? TMR_W'(SMALL_ERASE_CYC)
                        : TMR_W'(BLOCK_ERASE_CYC);
                    ep_nxt = !prot_sec;
                    ek_nxt = (op_r == OP_SUB_ERASE) ? 3'(SFPES_JOB_SUB)
                                                    : 3'(SFPES_JOB_SEC);
                    ea_nxt = addr_r;
                    if (prot_sec) begin
                        job_nxt = SFPES_JOB_NONE;
                        tmr_nxt = '0;
                    end
                end else if (op_r == OP_BULK_ERASE && nbyte_r == 8'h01
                             && protect_field == 3'h0) begin
                    job_nxt = SFPES_JOB_BULK;
                    tmr_nxt = TMR_W'(FULL_ERASE_CYC);
                    ep_nxt = 1'b1;
                    ek_nxt = 3'(SFPES_JOB_BULK);
                    ea_nxt = 24'h000000;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            sh_r <= 8'h00;
            op_r <= 8'h00;
            dat_r <= 8'h00;
            bit_r <= 3'h0;
            nbyte_r <= 8'h00;
            addr_r <= 24'h000000;
            on_bound_r <= 1'b0;
            otp_wr_r <= '0;
            otp_base_r <= 7'h00;
            wel_r <= 1'b0;
            job_r <= SFPES_JOB_NONE;
            pwr_r <= SFPES_PWR_STBY;
            tmr_r <= '0;
            ep_r <= 1'b0;
            ek_r <= 3'h0;
            ea_r <= 24'h000000;
        end else begin
            sh_r <= sh_nxt;
            op_r <= op_nxt;
            dat_r <= dat_nxt;
            bit_r <= bit_nxt;
            nbyte_r <= nbyte_nxt;
            addr_r <= addr_nxt;
            on_bound_r <= on_bound_nxt;
            otp_wr_r <= wr_mark;
            otp_base_r <= otp_base_nxt;
            wel_r <= wel_nxt;
            job_r <= job_nxt;
            pwr_r <= pwr_nxt;
            tmr_r <= tmr_nxt;
            ep_r <= ep_nxt;
            ek_r <= ek_nxt;
            ea_r <= ea_nxt;
        end
    end

    // lock bits: volatile, cleared by reset
    always_ff @(posedge clk_sys) begin
        for (int i = 0; i < SECTORS; i++) begin
            if (srst) begin
                lock_r[i] <= 2'h0;
            end else if (lock_we && sec_of(addr_r) == SEC_W'(i)) begin
                lock_r[i] <= lock_wv;
            end
        end
    end

    // otp array: nonvolatile model, erased to ones, bits only clear
    always_ff @(posedge clk_sys) begin
        for (int i = 0; i < OTP_MAX_LATCH; i++) begin
            if (otp_commit && otp_wr_r[i]) begin
                otp_buf_r[i] <= otp_buf_r[i] & otp_new_r[i];
            end
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            otp_read_data <= 8'h00;
            sector_lock_register <= 8'h00;
        end else begin
            otp_read_data <= (otp_read_idx < 7'(OTP_MAX_LATCH))
                ? otp_buf_r[otp_read_idx] : 8'hFF;
            sector_lock_register <= {6'h00, lock_r[lock_read_sec]};
        end
    end
    assign erase_pulse = ep_r;
    assign erase_kind = ek_r;
    assign erase_addr = ea_r;
    assign status = '{cycle_active_flag: busy, write_latch_flag: wel_r,
                      sleeping: (pwr_r == SFPES_PWR_SLEEP),
                      protect_field: protect_field};
endmodule : sfpes_core
`default_nettype wire

//--- test/sfpes_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module sfpes_host_model (
    input wire logic clk_sys,
    output logic chip_sel_n,
    output logic serial_clk,
    output logic serial_in_line
);
    logic [7:0] tx [0:71];
    initial begin
        chip_sel_n = 1'b1;
        serial_clk = 1'b0;
        serial_in_line = 1'b1;
    end
    task automatic half;
        repeat (4) @(negedge clk_sys);
    endtask : half
    // opcode, address, data msb first; select drops only at frame end
    task automatic send(input int nbits);
        chip_sel_n = 1'b0;
        half();
        for (int i = 0; i < nbits; i++) begin
            serial_in_line = tx[i / 8][7 - i % 8];
            half();
            serial_clk = 1'b1;
            half();
            serial_clk = 1'b0;
        end
        half();
        chip_sel_n = 1'b1;
        serial_in_line = ~serial_in_line;
        repeat (8) @(negedge clk_sys);
    endtask : send
endmodule : sfpes_host_model
`default_nettype wire

//--- test/sfpes_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module sfpes_monitor
    import sfpes_pkg::*;
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic chip_sel_n,
    input wire logic serial_clk,
    input wire logic serial_in_line,
    input wire logic [2:0] protect_field,
    input wire logic [SEC_W-1:0] hw_protect_sec,
    input wire logic hw_protect_hit,
    input wire logic [7:0] otp_read_data,
    input wire logic [6:0] otp_read_idx,
    input wire logic [7:0] sector_lock_register,
    input wire logic [SEC_W-1:0] lock_read_sec,
    input wire logic erase_pulse,
    input wire logic [2:0] erase_kind,
    input wire logic [23:0] erase_addr,
    input wire sfpes_status_t status
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);
    // ----------------------------------------
    // busy length counter
    // ----------------------------------------
    logic [15:0] hi_cnt_r;
    logic [15:0] hi_cnt_nxt;
    always_comb begin
        hi_cnt_nxt = status.cycle_active_flag ? hi_cnt_r + 16'h0001 : 16'h0000;
    end
    always_ff @(posedge clk_sys) begin
        hi_cnt_r <= srst ? 16'h0000 : hi_cnt_nxt;
    end
    property p_pulse_busy;
        erase_pulse |-> status.cycle_active_flag;
    endproperty
    a_pulse_busy: assert property (p_pulse_busy)
        else $error("idle erase");
    property p_pulse_latch;
        erase_pulse |-> ##1 !status.write_latch_flag;
    endproperty
    a_pulse_latch: assert property (p_pulse_latch)
        else $error("latch kept");
    property p_kind;
        erase_pulse |-> erase_kind inside {3'h2, 3'h3, 3'h4};
    endproperty
    a_kind: assert property (p_kind)
        else $error("bad erase kind");
    property p_bulk_prot;
        erase_pulse && erase_kind == 3'h4 |-> protect_field == 3'h0;
    endproperty
    a_bulk_prot: assert property (p_bulk_prot)
        else $error("bulk protected");
    property p_rise_latch;
        $rose(status.cycle_active_flag) |-> $past(status.write_latch_flag);
    endproperty
    a_rise_latch: assert property (p_rise_latch)
        else $error("no latch");
    property p_sleep_idle;
        status.sleeping |-> !status.cycle_active_flag && !erase_pulse;
    endproperty
    a_sleep_idle: assert property (p_sleep_idle)
        else $error("busy asleep");
    property p_len;
        $fell(status.cycle_active_flag) |-> hi_cnt_r inside {PAGE_WRITE_CYC,
            SMALL_ERASE_CYC, BLOCK_ERASE_CYC, FULL_ERASE_CYC};
    endproperty
    a_len: assert property (p_len)
        else $error("cycle length");
    property p_one_pulse;
        erase_pulse |=> !erase_pulse;
    endproperty
    a_one_pulse: assert property (p_one_pulse)
        else $error("long pulse");
    property p_deselected;
        $rose(status.cycle_active_flag) |-> chip_sel_n && $past(chip_sel_n, 2);
    endproperty
    a_deselected: assert property (p_deselected)
        else $error("selected");
endmodule : sfpes_monitor
bind sfpes_core sfpes_monitor sfpes_monitor_inst (.clk_sys(clk_sys),
    .srst(srst), .chip_sel_n(chip_sel_n), .serial_clk(serial_clk),
    .serial_in_line(serial_in_line), .protect_field(protect_field),
    .hw_protect_sec(hw_protect_sec), .hw_protect_hit(hw_protect_hit),
    .otp_read_data(otp_read_data), .otp_read_idx(otp_read_idx),
    .sector_lock_register(sector_lock_register),
    .lock_read_sec(lock_read_sec), .erase_pulse(erase_pulse),
    .erase_kind(erase_kind), .erase_addr(erase_addr), .status(status));
`default_nettype wire

//--- test/sfpes_tb.sv
`timescale 1ns/1ps
`default_nettype none
module sfpes_tb;
    import sfpes_pkg::*;
    logic clk_sys, srst, chip_sel_n, serial_clk, serial_in_line;
    logic [2:0] protect_field, erase_kind;
    logic [SEC_W-1:0] hw_protect_sec, lock_read_sec;
    logic hw_protect_hit, erase_pulse;
    logic [7:0] otp_read_data, sector_lock_register;
    logic [6:0] otp_read_idx;
    logic [23:0] erase_addr;
    sfpes_status_t status;
    int num_errors = 0;
    int compares = 0;
    int pulses = 0;
    sfpes_core sfpes_core_inst (.clk_sys(clk_sys), .srst(srst),
        .chip_sel_n(chip_sel_n), .serial_clk(serial_clk),
        .serial_in_line(serial_in_line), .protect_field(protect_field),
        .hw_protect_sec(hw_protect_sec), .hw_protect_hit(hw_protect_hit),
        .otp_read_data(otp_read_data), .otp_read_idx(otp_read_idx),
        .sector_lock_register(sector_lock_register),
        .lock_read_sec(lock_read_sec), .erase_pulse(erase_pulse),
        .erase_kind(erase_kind), .erase_addr(erase_addr), .status(status));
    sfpes_host_model sfpes_host_model_inst (.clk_sys(clk_sys),
        .chip_sel_n(chip_sel_n), .serial_clk(serial_clk),
        .serial_in_line(serial_in_line));
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    always @(negedge clk_sys) begin
        if (erase_pulse === 1'b1) pulses++;
    end
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic cmd(input logic [7:0] op, input int na,
        input logic [23:0] a, input int nd, input logic [7:0] d, input int ex);
        sfpes_host_model_inst.tx[0] = op;
        for (int i = 0; i < na; i++) begin
            sfpes_host_model_inst.tx[1 + i] = a[8 * (2 - i) +: 8];
        end
        for (int i = 0; i < nd; i++) begin
            sfpes_host_model_inst.tx[1 + na + i] = d;
        end
        sfpes_host_model_inst.send(8 * (1 + na + nd) + ex);
    endtask : cmd
    task automatic wren;
        cmd(OP_WREN, 0, 24'h0, 0, 8'h00, 0);
        check(status.write_latch_flag, 24'h1);
    endtask : wren
    task automatic wait_idle;
        int n;
        n = 0;
        while (status.cycle_active_flag === 1'b1 && n < 12000) begin
            @(negedge clk_sys);
            n++;
        end
        check(24'(n < 12000), 24'h1);
    endtask : wait_idle
    task automatic otp_chk(input logic [6:0] i, input logic [7:0] e);
        otp_read_idx = i;
        repeat (2) @(negedge clk_sys);
        check(otp_read_data, e);
    endtask : otp_chk
    task automatic lock_chk(input logic [4:0] s, input logic [7:0] e);
        lock_read_sec = s;
        repeat (2) @(negedge clk_sys);
        check(sector_lock_register, e);
    endtask : lock_chk
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset;
        check(status, 24'h0);
        lock_chk(5'h00, 8'h00);
        $display("reset test done");
    endtask : t_reset
    task automatic t_otp;
        cmd(OP_OTP_PROG, 3, 24'h0, 1, 8'hA5, 0);
        check(status.cycle_active_flag, 24'h0);
        wren();
        cmd(OP_OTP_PROG, 3, 24'h0, 1, 8'hA5, 3);
        check(status.cycle_active_flag, 24'h0);
        cmd(OP_OTP_PROG, 3, 24'h0, 1, 8'hA5, 0);
        check(status, 24'h20);
        wait_idle();
        otp_chk(7'h00, 8'hA5);
        wren();
        cmd(OP_OTP_PROG, 3, 24'h0, 1, 8'h5A, 0);
        wait_idle();
        otp_chk(7'h00, 8'h00);
        wren();
        cmd(OP_OTP_PROG, 3, 24'h40, 1, 8'hFE, 0);
        wait_idle();
        otp_chk(7'h40, 8'hFE);
        wren();
        cmd(OP_OTP_PROG, 3, 24'h1, 1, 8'h00, 0);
        wait_idle();
        otp_chk(7'h01, 8'hFF);
        $display("otp test done");
    endtask : t_otp
    task automatic t_lock;
        wren();
        cmd(OP_LOCK_WR, 3, 24'h03ABCD, 1, 8'h01, 0);
        check(status, 24'h0);
        lock_chk(5'h03, 8'h01);
        wren();
        cmd(OP_SEC_ERASE, 3, 24'h030000, 0, 8'h00, 0);
        check(status, 24'h10);
        cmd(OP_LOCK_WR, 3, 24'h040000, 1, 8'h01, 8);
        lock_chk(5'h04, 8'h00);
        cmd(OP_LOCK_WR, 3, 24'h03FFFF, 1, 8'h02, 0);
        lock_chk(5'h03, 8'h02);
        wren();
        cmd(OP_LOCK_WR, 3, 24'h030000, 1, 8'h00, 0);
        lock_chk(5'h03, 8'h02);
        $display("lock test done");
    endtask : t_lock
    task automatic t_erase;
        int p;
        p = pulses;
        wren();
        cmd(OP_SUB_ERASE, 3, 24'h012345, 0, 8'h00, 0);
        check(24'(pulses), 24'(p + 1));
        check({erase_kind, erase_addr[20:0]}, {3'h2, 21'h012345});
        cmd(OP_SLEEP, 0, 24'h0, 0, 8'h00, 0);
        repeat (SLEEP_ENTRY_CYC + 10) @(negedge clk_sys);
        check({status.sleeping, status.cycle_active_flag}, 24'h1);
        cmd(OP_SEC_ERASE, 3, 24'h020000, 0, 8'h00, 0);
        check(24'(pulses), 24'(p + 1));
        wait_idle();
        wren();
        cmd(OP_SEC_ERASE, 3, 24'h020000, 0, 8'h00, 1);
        check(24'(pulses), 24'(p + 1));
        cmd(OP_SEC_ERASE, 3, 24'h02FFFF, 0, 8'h00, 0);
        check({erase_kind, 21'(pulses)}, {3'h3, 21'(p + 2)});
        wait_idle();
        hw_protect_sec = 5'h05;
        hw_protect_hit = 1'b1;
        wren();
        cmd(OP_SUB_ERASE, 3, 24'h051000, 0, 8'h00, 0);
        check(24'(pulses), 24'(p + 2));
        hw_protect_hit = 1'b0;
        protect_field = 3'h1;
        cmd(OP_BULK_ERASE, 0, 24'h0, 0, 8'h00, 0);
        check(24'(pulses), 24'(p + 2));
        protect_field = 3'h0;
        cmd(OP_BULK_ERASE, 0, 24'h0, 0, 8'h00, 0);
        check({erase_kind, 21'(pulses)}, {3'h4, 21'(p + 3)});
        wait_idle();
        $display("erase test done");
    endtask : t_erase
    task automatic t_sleep;
        cmd(OP_SLEEP, 0, 24'h0, 0, 8'h00, 0);
        repeat (SLEEP_ENTRY_CYC + 10) @(negedge clk_sys);
        check(status.sleeping, 24'h1);
        cmd(OP_WREN, 0, 24'h0, 0, 8'h00, 0);
        check(status.write_latch_flag, 24'h0);
        cmd(OP_WAKE, 0, 24'h0, 0, 8'h00, 0);
        repeat (SLEEP_EXIT_CYC + 10) @(negedge clk_sys);
        check(status.sleeping, 24'h0);
        wren();
        cmd(OP_WRDI, 0, 24'h0, 0, 8'h00, 0);
        check(status.write_latch_flag, 24'h0);
        $display("sleep test done");
    endtask : t_sleep
    task automatic finish_test;
        $display("compares=%0d mismatches=%0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : finish_test
    initial begin
        repeat (60000) @(posedge clk_sys);
        num_errors++;
        finish_test();
    end
    initial begin
        srst = 1'b1;
        protect_field = 3'h0;
        hw_protect_sec = 5'h00;
        hw_protect_hit = 1'b0;
        otp_read_idx = 7'h00;
        lock_read_sec = 5'h00;
        repeat (16) @(negedge clk_sys);
        srst = 1'b0;
        repeat (4) @(negedge clk_sys);
        t_reset();
        t_otp();
        t_lock();
        t_erase();
        t_sleep();
        finish_test();
    end
endmodule : sfpes_tb
`default_nettype wire
